// ===== common/bst_pkg.sv
package bst_pkg;

   // ----------------------------------------
   // Widths and lengths
   // ----------------------------------------
   localparam int IR_W = 4;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int N_PINS = 12;
   localparam int BSR_LEN = 24;
   localparam int DR_W = 32;
   localparam int FIFO_DEPTH = 8;

   // ----------------------------------------
   // Instruction codes
   // ----------------------------------------
   localparam logic [3:0] IR_BYPASS = 4'h0;
   localparam logic [3:0] IR_SAMPLE = 4'h1;
   localparam logic [3:0] IR_IDCODE = 4'h2;
   localparam logic [3:0] IR_USER = 4'h3;
   localparam logic [3:0] IR_CLAMP = 4'h4;
   localparam logic [3:0] IR_HIGHZ = 4'h5;
   localparam logic [3:0] IR_EXTEST = 4'h7;
   localparam logic [3:0] IR_IFACE = 4'h8;
   localparam logic [3:0] IR_REG_RD = 4'h9;
   localparam logic [3:0] IR_REG_WR = 4'ha;
   localparam logic [3:0] IR_CAPTURE = 4'h1;

   // ----------------------------------------
   // Data register lengths per instruction
   // ----------------------------------------
   localparam logic [5:0] LEN_BYPASS = 6'h01;
   localparam logic [5:0] LEN_BSR = 6'h18;
   localparam logic [5:0] LEN_WORD = 6'h20;
   localparam logic [5:0] LEN_REG = 6'h0f;

   // Identity words, values arbitrary
   localparam logic [31:0] ID_WORD = 32'h1234_5671;
   localparam logic [31:0] USER_WORD = 32'h0000_0001;

   // Synchroniser reset level: pull-ups make TCK and TMS idle high
   localparam logic [2:0] SYNC_RST = 3'h3;

   // ----------------------------------------
   // Controller states
   // ----------------------------------------
   typedef enum logic [15:0] {
      ST_TLR = 16'h0001,
      ST_IDLE = 16'h0002,
      ST_SEL_DR = 16'h0004,
      ST_CAP_DR = 16'h0008,
      ST_SH_DR = 16'h0010,
      ST_EX1_DR = 16'h0020,
      ST_PAU_DR = 16'h0040,
      ST_EX2_DR = 16'h0080,
      ST_UPD_DR = 16'h0100,
      ST_SEL_IR = 16'h0200,
      ST_CAP_IR = 16'h0400,
      ST_SH_IR = 16'h0800,
      ST_EX1_IR = 16'h1000,
      ST_PAU_IR = 16'h2000,
      ST_EX2_IR = 16'h4000,
      ST_UPD_IR = 16'h8000
   } bst_state_e;

   // Internal register write request
   typedef struct packed {
      logic [6:0] addr;
      logic [7:0] data;
   } bst_wr_s;

endpackage : bst_pkg

// ===== logic/bst_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module bst_fifo #(
   parameter int W = 15,
   parameter int DEPTH = 8
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_valid,
   input wire logic [W-1:0] i_data,
   output logic o_ready,
   output logic o_valid,
   output logic [W-1:0] o_data,
   input wire logic i_ready
);

   localparam int PW = $clog2(DEPTH);

   // ----------------------------------------
   // Parameter check
   // ----------------------------------------
   if (DEPTH < 2 || (1 << PW) != DEPTH || W < 1) begin : g_bad
      $error("bst_fifo: DEPTH must be a power of two, at least 2");
   end

   logic [W-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [PW:0] count_reg;
   wire push = i_valid && o_ready;
   wire pop = o_valid && i_ready;

   // Honest flags from the fill count
   assign o_ready = count_reg != (PW+1)'(DEPTH);
   assign o_valid = count_reg != '0;
   assign o_data = mem[rd_ptr_reg];

   // Storage write
   always_ff @(posedge i_sys_clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= i_data;
      end
   end

   // Pointers and count
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
         if (push && !pop) count_reg <= count_reg + 1'b1;
         else if (pop && !push) count_reg <= count_reg - 1'b1;
      end
   end

endmodule : bst_fifo

`default_nettype wire

// ===== logic/bst_tap.sv
// Function
// - TCK, TMS, TDI in, TDO out; TDI shifts through selected chain to TDO.
// - All test logic advances only on detected TCK edges, except the write queue and output stage, which drain on the system clock.
// - Static TCK at either level leaves state and registers unchanged.
// - TMS sampled at rising TCK picks next controller state.
// - Five TCK cycles with TMS high reach Test-Logic-Reset from anywhere.
// - Entering Test-Logic-Reset loads the ID code instruction.
// - Code 2 shifts 32-bit ID word, code 3 32-bit user word.
// - Code 8 takes one bit switching host interfaces off or on.
// - Code 9 takes 7-bit address, returns 8-bit register content.
// - Code 10 takes 7-bit address then 8 data bits to write.
// - Each pin has a test cell overriding its normal function.
// - TCK and TMS pulled up: undriven means no clock, TMS high.
// - TDI sampled at rising TCK into instruction or selected data chain.
// - TDO changes at falling TCK, inactive when not shifting.
// - Read: Capture-DR loads current address; Update-DR adopts new address.
// - Interface bit one at Update-DR disables host, enables register access.
`timescale 1ns/1ps
`default_nettype none

module bst_tap (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_tck,
   input wire logic i_tms,
   input wire logic i_tdi,
   output logic o_tdo,
   output logic o_tdo_oe_n,
   input wire logic [bst_pkg::N_PINS-1:0] i_pin_in,
   input wire logic [bst_pkg::N_PINS-1:0] i_func_out,
   input wire logic [bst_pkg::N_PINS-1:0] i_func_oe_n,
   output logic [bst_pkg::N_PINS-1:0] o_pin_out,
   output logic [bst_pkg::N_PINS-1:0] o_pin_oe_n,
   output logic o_host_if_off,
   output logic [bst_pkg::ADDR_W-1:0] o_rd_addr,
   input wire logic [bst_pkg::DATA_W-1:0] i_rd_data,
   output logic o_wr_valid,
   output logic [bst_pkg::ADDR_W-1:0] o_wr_addr,
   output logic [bst_pkg::DATA_W-1:0] o_wr_data,
   input wire logic i_wr_ready
);

   localparam int NP = bst_pkg::N_PINS;
   localparam int SW = 3 + NP;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [SW-1:0] s1_reg;
   logic [SW-1:0] s2_reg;
   logic [SW-1:0] s3_reg;
   logic [SW-1:0] filt_reg;
   logic tck_prev_reg;

   // Three stages, a level counts once stages two and three agree
   // pull-up idle levels
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         s1_reg <= {{NP{1'b0}}, bst_pkg::SYNC_RST};
         s2_reg <= {{NP{1'b0}}, bst_pkg::SYNC_RST};
         s3_reg <= {{NP{1'b0}}, bst_pkg::SYNC_RST};
         filt_reg <= {{NP{1'b0}}, bst_pkg::SYNC_RST};
         tck_prev_reg <= 1'b1;
      end else begin
         s1_reg <= {i_pin_in, i_tdi, i_tms, i_tck};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
         tck_prev_reg <= filt_reg[0];
      end
   end

   // TCK edge enables
   // only TCK edges advance
   wire tck_f = filt_reg[0];
   wire tms_f = filt_reg[1];
   wire tdi_f = filt_reg[2];
   wire [NP-1:0] pins_f = filt_reg[SW-1:3];
   wire tck_rise = tck_f && !tck_prev_reg;
   wire tck_fall = !tck_f && tck_prev_reg;

   // ----------------------------------------
   // Controller state machine
   // ----------------------------------------
   bst_pkg::bst_state_e state_reg;
   bst_pkg::bst_state_e state_next;

   always_comb begin
      case (state_reg)
         bst_pkg::ST_TLR: state_next = tms_f ? bst_pkg::ST_TLR : bst_pkg::ST_IDLE;
         bst_pkg::ST_IDLE: state_next = tms_f ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         bst_pkg::ST_SEL_DR: state_next = tms_f ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
         bst_pkg::ST_CAP_DR: state_next = tms_f ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
         bst_pkg::ST_SH_DR: state_next = tms_f ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
         bst_pkg::ST_EX1_DR: state_next = tms_f ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAU_DR;
         bst_pkg::ST_PAU_DR: state_next = tms_f ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PAU_DR;
         bst_pkg::ST_EX2_DR: state_next = tms_f ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
         bst_pkg::ST_UPD_DR: state_next = tms_f ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         bst_pkg::ST_SEL_IR: state_next = tms_f ? bst_pkg::ST_TLR : bst_pkg::ST_CAP_IR;
         bst_pkg::ST_CAP_IR: state_next = tms_f ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
         bst_pkg::ST_SH_IR: state_next = tms_f ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
         bst_pkg::ST_EX1_IR: state_next = tms_f ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAU_IR;
         bst_pkg::ST_PAU_IR: state_next = tms_f ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PAU_IR;
         bst_pkg::ST_EX2_IR: state_next = tms_f ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
         bst_pkg::ST_UPD_IR: state_next = tms_f ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         default: state_next = bst_pkg::ST_TLR;
      endcase
   end

   // state moves only on a rising edge
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) state_reg <= bst_pkg::ST_TLR;
      else if (tck_rise) state_reg <= state_next;
   end

   // State decodes
   wire in_tlr = state_reg == bst_pkg::ST_TLR;
   wire cap_dr = state_reg == bst_pkg::ST_CAP_DR;
   wire sh_dr = state_reg == bst_pkg::ST_SH_DR;
   wire upd_dr = state_reg == bst_pkg::ST_UPD_DR;
   wire cap_ir = state_reg == bst_pkg::ST_CAP_IR;
   wire sh_ir = state_reg == bst_pkg::ST_SH_IR;
   wire upd_ir = state_reg == bst_pkg::ST_UPD_IR;

   // ----------------------------------------
   // Instruction register
   // ----------------------------------------
   logic [bst_pkg::IR_W-1:0] ir_reg;
   logic [bst_pkg::IR_W-1:0] ir_sh_reg;

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         ir_reg <= bst_pkg::IR_IDCODE;
         ir_sh_reg <= '0;
      end else if (in_tlr) begin
         ir_reg <= bst_pkg::IR_IDCODE;
      end else if (tck_rise) begin
         if (cap_ir) ir_sh_reg <= bst_pkg::IR_CAPTURE;
         if (sh_ir) ir_sh_reg <= {tdi_f, ir_sh_reg[bst_pkg::IR_W-1:1]};
         if (upd_ir) ir_reg <= ir_sh_reg;
      end
   end

   // Instruction decodes
   wire i_bsr = ir_reg == bst_pkg::IR_SAMPLE || ir_reg == bst_pkg::IR_EXTEST;
   wire i_id = ir_reg == bst_pkg::IR_IDCODE;
   wire i_user = ir_reg == bst_pkg::IR_USER;
   wire i_if = ir_reg == bst_pkg::IR_IFACE;
   wire i_rd = ir_reg == bst_pkg::IR_REG_RD;
   wire i_wr = ir_reg == bst_pkg::IR_REG_WR;
   wire i_drive = ir_reg == bst_pkg::IR_EXTEST || ir_reg == bst_pkg::IR_CLAMP;
   wire i_float = ir_reg == bst_pkg::IR_HIGHZ;

   // unlisted codes fall through to the bypass length
   // clamp and high-impedance use the bypass bit
   wire [5:0] dr_len = i_bsr ? bst_pkg::LEN_BSR :
                       (i_id || i_user) ? bst_pkg::LEN_WORD :
                       (i_rd || i_wr) ? bst_pkg::LEN_REG : bst_pkg::LEN_BYPASS;

   // ----------------------------------------
   // Data register and pin cells
   // ----------------------------------------
   logic [bst_pkg::DR_W-1:0] dr_reg;
   logic [bst_pkg::BSR_LEN-1:0] bsr_upd_reg;
   logic [bst_pkg::ADDR_W-1:0] addr_reg;
   logic iface_off_reg;
   logic [bst_pkg::BSR_LEN-1:0] bsr_cap;
   wire [NP-1:0] cell_data;
   wire [NP-1:0] cell_ctrl;

   // data cell at even position, control cell above it
   for (genvar k = 0; k < NP; k++) begin : g_cell
      assign bsr_cap[2*k] = pins_f[k];
      assign bsr_cap[2*k+1] = ~i_func_oe_n[k];
      assign cell_data[k] = bsr_upd_reg[2*k];
      assign cell_ctrl[k] = bsr_upd_reg[2*k+1];
   end

   // Capture values by instruction
   // pins, words, read data over address
   wire [bst_pkg::DR_W-1:0] dr_cap =
      i_bsr ? {8'h00, bsr_cap} :
      i_id ? bst_pkg::ID_WORD :
      i_user ? bst_pkg::USER_WORD :
      i_rd ? {17'h00000, (iface_off_reg ? i_rd_data : 8'h00), addr_reg} : 32'h0000_0000;

   // TDI enters at the top of the selected length
   wire [bst_pkg::DR_W-1:0] top_bit = 32'h0000_0001 << (dr_len - 6'h01);
   wire [bst_pkg::DR_W-1:0] dr_shift = ((dr_reg >> 1) & ~top_bit) | (tdi_f ? top_bit : 32'h0000_0000);

   // Data register walk through capture, shift and update
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst || in_tlr) begin
         dr_reg <= '0;
         iface_off_reg <= 1'b0;
      end else if (tck_rise) begin
         if (cap_dr) dr_reg <= dr_cap;
         if (sh_dr) dr_reg <= dr_shift;
         if (upd_dr && i_if) iface_off_reg <= dr_reg[0];
      end
   end

   // Update latches: boundary cells and current address
   // preload and drive values, new address
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         bsr_upd_reg <= '0;
         addr_reg <= '0;
      end else if (tck_rise && upd_dr) begin
         if (i_bsr) bsr_upd_reg <= dr_reg[bst_pkg::BSR_LEN-1:0];
         if (i_rd && iface_off_reg) addr_reg <= dr_reg[bst_pkg::ADDR_W-1:0];
      end
   end

   // Pin drive: test cells override normal function
   // clamp and extest drive, high-z floats
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_pin_out <= '0;
         o_pin_oe_n <= '1;
      end else begin
         o_pin_out <= i_drive ? cell_data : i_func_out;
         o_pin_oe_n <= i_float ? '1 : i_drive ? ~cell_ctrl : i_func_oe_n;
      end
   end

   // ----------------------------------------
   // Register write path
   // ----------------------------------------
   logic pend_reg;
   bst_pkg::bst_wr_s pend_data_reg;
   bst_pkg::bst_wr_s fifo_out;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire out_take = !o_wr_valid || i_wr_ready;
   // capture at Capture-DR takes the address and data shifted in by the previous scan
   wire wr_cap = tck_rise && cap_dr && i_wr && iface_off_reg && !pend_reg;

   // Pending request waits for FIFO room; a new one is refused meanwhile
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         pend_reg <= 1'b0;
         pend_data_reg <= '0;
      end else if (wr_cap) begin
         pend_reg <= 1'b1;
         pend_data_reg <= {dr_reg[bst_pkg::ADDR_W-1:0], dr_reg[14:7]};
      end else if (fifo_in_ready) begin
         pend_reg <= 1'b0;
      end
   end

   // Write request queue
   bst_fifo #(
      .W($bits(bst_pkg::bst_wr_s)),
      .DEPTH(bst_pkg::FIFO_DEPTH)
   ) u_fifo (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_valid(pend_reg),
      .i_data(pend_data_reg),
      .o_ready(fifo_in_ready),
      .o_valid(fifo_out_valid),
      .o_data(fifo_out),
      .i_ready(out_take)
   );

   // Output stage of the write port
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_wr_valid <= 1'b0;
         o_wr_addr <= '0;
         o_wr_data <= '0;
      end else if (out_take) begin
         o_wr_valid <= fifo_out_valid;
         o_wr_addr <= fifo_out.addr;
         o_wr_data <= fifo_out.data;
      end
   end

   // ----------------------------------------
   // TDO and status outputs
   // ----------------------------------------
   // TDO moves on falling TCK, released when idle
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_tdo <= 1'b0;
         o_tdo_oe_n <= 1'b1;
         o_host_if_off <= 1'b0;
         o_rd_addr <= '0;
      end else begin
         o_host_if_off <= iface_off_reg;
         o_rd_addr <= addr_reg;
         if (tck_fall) begin
            o_tdo <= sh_ir ? ir_sh_reg[0] : sh_dr ? dr_reg[0] : 1'b0;
            o_tdo_oe_n <= !(sh_ir || sh_dr);
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   logic [2:0] tms_cnt_reg;

   // Count rising edges with TMS high, saturating at five
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) tms_cnt_reg <= '0;
      else if (tck_rise) tms_cnt_reg <= !tms_f ? 3'h0 : (tms_cnt_reg == 3'h5) ? 3'h5 : tms_cnt_reg + 3'h1;
   end

   five_tms_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      tms_cnt_reg == 3'h5 |-> state_reg == bst_pkg::ST_TLR)
      else $error("five TMS high did not reach reset state");

   tlr_ir_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      tck_rise && state_next == bst_pkg::ST_TLR |=> ##1 ir_reg == bst_pkg::IR_IDCODE)
      else $error("instruction not ID code after reset state");

   static_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      !tck_rise && !in_tlr |=> $stable(state_reg) && $stable(ir_reg) && $stable(dr_reg))
      else $error("state changed without TCK edge");

   tms_step_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      tck_rise && state_reg == bst_pkg::ST_IDLE && tms_f |=> state_reg == bst_pkg::ST_SEL_DR)
      else $error("TMS high from idle did not select DR");

   bypass_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      tck_rise && sh_dr && ir_reg == bst_pkg::IR_BYPASS |=> dr_reg[0] == $past(tdi_f))
      else $error("bypass bit did not take TDI");

   tdo_edge_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      !tck_fall |=> $stable(o_tdo) && $stable(o_tdo_oe_n))
      else $error("TDO changed away from falling TCK");

   tdo_idle_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      tck_fall && !sh_dr && !sh_ir |=> o_tdo_oe_n)
      else $error("TDO driven while not shifting");

   iface_upd_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      tck_rise && upd_dr && i_if |=> ##1 o_host_if_off == $past(dr_reg[0], 2))
      else $error("interface switch not taken at update");

   addr_upd_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      tck_rise && upd_dr && i_rd && iface_off_reg |=> addr_reg == $past(dr_reg[6:0]))
      else $error("read address not adopted at update");

endmodule : bst_tap

`default_nettype wire

// ===== tb/bst_tester.sv
`timescale 1ns/1ps
`default_nettype none

module bst_tester (
   input wire logic i_sys_clk,
   input wire logic i_tdo,
   input wire logic i_tdo_oe_n,
   output logic o_tck,
   output logic o_tms,
   output logic o_tdi
);
   int stall = 0;
   logic oe_seen = 1'b0;

   // ----------------------------------------
   // Link idle levels
   // ----------------------------------------
   // pull-up idle
   initial begin
      o_tck = 1'b1;
      o_tms = 1'b1;
      o_tdi = 1'b0;
   end

   // One test clock period of 8 system clocks, low phase first; stall stretches the low phase
   // change on fall
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      @(posedge i_sys_clk);
      o_tck <= 1'b0;
      o_tms <= tms;
      o_tdi <= tdi;
      repeat (4 + stall) @(posedge i_sys_clk);
      o_tck <= 1'b1;
      repeat (3) @(posedge i_sys_clk);
      tdo = i_tdo;
      oe_seen = oe_seen | ~i_tdo_oe_n;
   endtask : step

   // Mode bits only, first bit in bit 0
   task automatic walk(input logic [7:0] tms, input int n);
      logic d;
      for (int i = 0; i < n; i++) begin
         step(tms[i], o_tdi, d);
      end
   endtask : walk

   // Shift n bits LSB first, leaving by the last bit; data line then shows the inverse
   task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
      logic d;
      dout = 32'h0;
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], d);
         dout[i] = d;
      end
      o_tdi <= ~din[n - 1];
   endtask : shift

   // Instruction scan from idle back to idle
   task automatic scan_ir(input logic [3:0] code, output logic [31:0] cap);
      walk(8'h03, 4);
      shift(4, 32'(code), cap);
      walk(8'h01, 2);
   endtask : scan_ir

   // Data scan from idle back to idle
   task automatic scan_dr(input int n, input logic [31:0] din, output logic [31:0] dout);
      walk(8'h01, 3);
      shift(n, din, dout);
      walk(8'h01, 2);
   endtask : scan_dr

   // Five mode-high periods reach reset, one low period reaches idle
   // reset sequence
   task automatic tap_reset();
      walk(8'h1f, 6);
   endtask : tap_reset
endmodule : bst_tester

`default_nettype wire

// ===== tb/test_boundary_scan_tap.sv
`timescale 1ns/1ps
`default_nettype none

module test_boundary_scan_tap;
   logic i_sys_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic tck, tms, tdi, tdo, tdo_oe_n, host_off, wr_valid;
   logic i_wr_ready = 1'b0;
   logic [11:0] pin_in = 12'ha5c;
   logic [11:0] func_out = 12'h6e1;
   logic [11:0] func_oe_n = 12'h3c3;
   logic [11:0] pin_out, pin_oe_n;
   logic [6:0] rd_addr, wr_addr;
   logic [7:0] rd_data, wr_data;
   logic [31:0] d;
   int err_count = 0;
   int tests_run = 0;

   // ----------------------------------------
   // Clock, register source, instances
   // ----------------------------------------
   always #10 i_sys_clk = ~i_sys_clk;
   assign rd_data = {rd_addr, 1'b1};

   bst_tap bst_tap_inst (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_tck(tck), .i_tms(tms),
      .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe_n(tdo_oe_n), .i_pin_in(pin_in), .i_func_out(func_out),
      .i_func_oe_n(func_oe_n), .o_pin_out(pin_out), .o_pin_oe_n(pin_oe_n), .o_host_if_off(host_off),
      .o_rd_addr(rd_addr), .i_rd_data(rd_data), .o_wr_valid(wr_valid), .o_wr_addr(wr_addr),
      .o_wr_data(wr_data), .i_wr_ready(i_wr_ready));

   bst_tester bst_tester_inst (.i_sys_clk(i_sys_clk), .i_tdo(tdo), .i_tdo_oe_n(tdo_oe_n),
      .o_tck(tck), .o_tms(tms), .o_tdi(tdi));

   // ----------------------------------------
   // Compare and verdict
   // ----------------------------------------
   task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : cmp

   task automatic wrap_up();
      if (err_count == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up

   // Boundary cells: even cell pin level, odd cell drive enable
   function automatic logic [23:0] cells(input logic [11:0] p, input logic [11:0] oe_n);
      logic [23:0] c;
      for (int k = 0; k < 12; k++) begin
         c[2*k] = p[k];
         c[2*k+1] = ~oe_n[k];
      end
      return c;
   endfunction : cells

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      cmp("tdo_oe_n", 32'h1, 32'(tdo_oe_n));
      cmp("host_off", 32'h0, 32'(host_off));
      cmp("wr_valid", 32'h0, 32'(wr_valid));
   endtask : t_reset

   // Default instruction read across a long frozen clock
   task automatic t_idcode();
      bst_tester_inst.tap_reset();
      bst_tester_inst.stall = 60;
      bst_tester_inst.scan_dr(32, 32'h0, d);
      bst_tester_inst.stall = 0;
      cmp("idcode", bst_pkg::ID_WORD, d);
      cmp("oe_shift", 32'h1, 32'(bst_tester_inst.oe_seen));
      cmp("oe_idle", 32'h1, 32'(tdo_oe_n));
   endtask : t_idcode

   task automatic t_user();
      bst_tester_inst.scan_ir(bst_pkg::IR_USER, d);
      cmp("ir_capture", 32'h1, d);
      bst_tester_inst.scan_dr(32, 32'h0, d);
      cmp("usercode", bst_pkg::USER_WORD, d);
   endtask : t_user

   // One-bit paths: listed and unlisted codes
   task automatic t_bypass();
      logic [3:0] codes [6] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'hb, 4'hf};
      foreach (codes[i]) begin
         bst_tester_inst.scan_ir(codes[i], d);
         bst_tester_inst.scan_dr(8, 32'h5a, d);
         cmp("bypass", 32'hb4, 32'(d[7:0]));
      end
   endtask : t_bypass

   // Sample and preload, then drive under extest and clamp, float, release
   task automatic t_pins();
      logic [23:0] pre;
      logic [11:0] eo, en;
      pre = 24'h9b36e1;
      for (int k = 0; k < 12; k++) begin
         eo[k] = pre[2*k];
         en[k] = ~pre[2*k+1];
      end
      bst_tester_inst.scan_ir(bst_pkg::IR_SAMPLE, d);
      bst_tester_inst.scan_dr(24, 32'(pre), d);
      cmp("sample", 32'(cells(pin_in, func_oe_n)), d);
      for (int i = 0; i < 2; i++) begin
         bst_tester_inst.scan_ir(i == 0 ? bst_pkg::IR_EXTEST : bst_pkg::IR_CLAMP, d);
         repeat (5) @(posedge i_sys_clk);
         cmp("pin_out", 32'(eo), 32'(pin_out));
         cmp("pin_oe_n", 32'(en), 32'(pin_oe_n));
      end
      bst_tester_inst.scan_ir(bst_pkg::IR_HIGHZ, d);
      repeat (5) @(posedge i_sys_clk);
      cmp("highz", 32'hfff, 32'(pin_oe_n));
      bst_tester_inst.scan_ir(bst_pkg::IR_BYPASS, d);
      repeat (5) @(posedge i_sys_clk);
      cmp("func_out", 32'(func_out), 32'(pin_out));
      cmp("func_oe", 32'(func_oe_n), 32'(pin_oe_n));
   endtask : t_pins

   // Switch interfaces, then read address 0 and adopt a new address
   task automatic t_regs();
      bst_tester_inst.scan_ir(bst_pkg::IR_IFACE, d);
      bst_tester_inst.scan_dr(1, 32'h1, d);
      repeat (5) @(posedge i_sys_clk);
      cmp("host_off", 32'h1, 32'(host_off));
      bst_tester_inst.scan_ir(bst_pkg::IR_REG_RD, d);
      bst_tester_inst.scan_dr(15, 32'h35, d);
      cmp("rd_first", 32'h0080, d);
      // Update-DR rise is filtered after the scan returns
      repeat (5) @(posedge i_sys_clk);
      cmp("rd_addr", 32'h35, 32'(rd_addr));
      bst_tester_inst.scan_dr(15, 32'h35, d);
      cmp("rd_second", 32'h35b5, d);
   endtask : t_regs

   // Writes pile up against a stalled consumer, then drain with stalls
   task automatic t_fifo();
      bst_pkg::bst_wr_s q [$];
      bst_tester_inst.scan_ir(bst_pkg::IR_REG_WR, d);
      for (int i = 1; i <= 13; i++) begin
         bst_tester_inst.scan_dr(15, {17'h0, 8'(8'ha0 + i), 7'(i)}, d);
      end
      cmp("wr_pending", 32'h1, 32'(wr_valid));
      for (int c = 0; c < 200; c++) begin
         @(posedge i_sys_clk);
         if (wr_valid === 1'b1 && i_wr_ready === 1'b1) begin
            q.push_back({wr_addr, wr_data});
         end
         i_wr_ready <= c[0];
      end
      // Oldest entry carries the address left by the last read scan
      cmp("wr_stale", 32'h35, 32'(q[0].addr));
      void'(q.pop_front());
      // Output stage, eight queued and one pending; later captures refused
      cmp("fill_count", 32'h9, 32'(q.size()));
      foreach (q[i]) begin
         cmp("wr_entry", {17'h0, 7'(i + 1), 8'(8'ha1 + i)}, 32'(q[i]));
      end
      cmp("wr_empty", 32'h0, 32'(wr_valid));
   endtask : t_fifo

   // Reset sequence from mid-shift with bypass loaded
   task automatic t_tlr();
      bst_tester_inst.scan_ir(bst_pkg::IR_BYPASS, d);
      bst_tester_inst.walk(8'h01, 3);
      bst_tester_inst.tap_reset();
      repeat (5) @(posedge i_sys_clk);
      cmp("host_off", 32'h0, 32'(host_off));
      bst_tester_inst.scan_dr(32, 32'h0, d);
      cmp("idcode", bst_pkg::ID_WORD, d);
   endtask : t_tlr

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge i_sys_clk);
      t_reset();
      i_sys_rst <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      t_idcode();
      t_user();
      t_bypass();
      t_pins();
      t_regs();
      t_fifo();
      t_tlr();
      wrap_up();
   end

   initial begin
      #1000000;
      err_count++;
      wrap_up();
   end
endmodule : test_boundary_scan_tap

`default_nettype wire
